// ---- verilog/cmdsel_pkg.sv ----
// package: constants and types for the command source selection block
package cmdsel_pkg;
	// setting values
	localparam logic [15:0] CMDSEL_SRC_COMM = 16'h0000;
	localparam logic [15:0] CMDSEL_SRC_EXT = 16'h0001;
	localparam logic [15:0] CMDSEL_SRC_EXT_FB = 16'h0002;
	localparam logic [15:0] CMDSEL_NET_OPTION = 16'h0000;
	localparam logic [15:0] CMDSEL_NET_PUCONN = 16'h0002;
	localparam logic [15:0] CMDSEL_SET_AUTO = 16'h270f;
	localparam logic [15:0] CMDSEL_PU_PUCONN = 16'h0002;
	localparam logic [15:0] CMDSEL_PU_USB = 16'h0003;
	localparam logic [15:0] CMDSEL_PU_PANEL = 16'h0004;
	// reset values of the settings
	localparam logic [15:0] CMDSEL_START_RST = 16'h0000;
	localparam logic [15:0] CMDSEL_FREQ_RST = 16'h0000;
	localparam logic [15:0] CMDSEL_NET_RST = 16'h270f;
	localparam logic [15:0] CMDSEL_PANEL_RST = 16'h270f;
	// register select codes on the settings write port
	localparam logic [1:0] CMDSEL_REG_START = 2'h0;
	localparam logic [1:0] CMDSEL_REG_FREQ = 2'h1;
	localparam logic [1:0] CMDSEL_REG_NET = 2'h2;
	localparam logic [1:0] CMDSEL_REG_PANEL = 2'h3;
	// interface identifiers, one-hot bit positions
	localparam int CMDSEL_IF_PANEL = 0;
	localparam int CMDSEL_IF_USB = 1;
	localparam int CMDSEL_IF_PUNIT = 2;
	localparam int CMDSEL_IF_RS485 = 3;
	localparam int CMDSEL_IF_OPTION = 4;
	localparam int CMDSEL_NIF = 5;
	// operation modes seen by this block
	typedef enum logic [1:0] {
		CMDSEL_MODE_EXT,
		CMDSEL_MODE_PU,
		CMDSEL_MODE_NET
	} cmdsel_mode_t;
endpackage

// ---- verilog/cmdsel_grant.sv ----
// grant decoder: owner of local_unit_mode and network_mode rights
`timescale 1ns/1ns
module cmdsel_grant
	import cmdsel_pkg::*;
(
	// latched settings
	input wire logic [15:0] net_set,
	input wire logic [15:0] pu_set,
	// attachment detection
	input wire logic usb_att,
	input wire logic punit_att,
	input wire logic option_fit,
	// decoded one-hot owners
	output logic [CMDSEL_NIF-1:0] pu_owner,
	output logic [CMDSEL_NIF-1:0] net_owner,
	output logic net_block
);
	logic [CMDSEL_NIF-1:0] pu_auto;
	logic net_to_option;
	logic both_pu;

	// attachment priority usb, then parameter unit, then panel
	assign pu_auto = usb_att ? (5'h01 << CMDSEL_IF_USB) :
		punit_att ? (5'h01 << CMDSEL_IF_PUNIT) :
		(5'h01 << CMDSEL_IF_PANEL);

	// rs485 traffic never steers local rights; fixed or auto only
	always_comb begin
		case (pu_set)
			CMDSEL_PU_PUCONN: pu_owner = 5'h01 << CMDSEL_IF_RS485;
			CMDSEL_PU_USB: pu_owner = 5'h01 << CMDSEL_IF_USB;
			CMDSEL_PU_PANEL: pu_owner = 5'h01 << CMDSEL_IF_PANEL;
			default: pu_owner = pu_auto;
		endcase
	end

	// network rights to option or to the pu connector
	assign net_to_option = (net_set == CMDSEL_NET_OPTION) ||
		((net_set != CMDSEL_NET_PUCONN) && option_fit);
	assign both_pu = (net_set == CMDSEL_NET_PUCONN) &&
		(pu_set == CMDSEL_PU_PUCONN);
	assign net_owner = net_to_option ? (5'h01 << CMDSEL_IF_OPTION) :
		(5'h01 << CMDSEL_IF_RS485);

	// block network mode with no option fitted where it is needed
	assign net_block = !option_fit &&
		(net_to_option || both_pu);
endmodule

// ---- verilog/cmdsel_top.sv ----
// command source selection: settings, sampling, grants and request gating
`timescale 1ns/1ns
// Summary of operation
// - start source: 0 communication, 1 external terminals; resets to 0.
// - frequency source: 0 comm, 1 external, 2 external else comm.
// - network setting 0 grants network rights only to the option.
// - network setting 2 grants network rights to rs485 on pu connector.
// - network auto: option when fitted, else rs485 on the pu connector.
// - local setting 2 pu connector, 3 usb, 4 operation panel.
// - local auto: usb first, then parameter unit, then panel.
// - rs485 traffic never moves local rights to the pu connector.
// - both settings 2: local wins; no option means no network mode.
// - option granted but not fitted blocks switching to network mode.
// - changed settings take effect only at reset or power-on.
// - modbus rtu rejected in local mode; hosts use network mode.
// - mode lamps off in local mode whenever panel is not the command source.
// - reads and monitoring accepted from any interface, any mode.
// - writes and starts run only from the interface holding rights.
// - network and local settings writable despite write protection.
// - settings writable with user group read 0 or option connected.
module cmdsel_top
	import cmdsel_pkg::*;
(
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// settings write port
	input wire logic set_wr,
	input wire logic [1:0] set_sel,
	input wire logic [15:0] set_wdata,
	input wire logic [15:0] user_group_read_selection,
	input wire logic [15:0] write_protect_selection,
	output logic set_wr_ack,
	output logic set_wr_nak,
	// settings read port
	input wire logic [1:0] rd_sel,
	output logic [15:0] rd_data,
	// mode and attachment
	input wire cmdsel_mode_t mode,
	input wire logic usb_att,
	input wire logic punit_att,
	input wire logic option_fit,
	input wire logic ext_freq_present,
	// requests from interfaces, one bit each
	input wire logic [CMDSEL_NIF-1:0] req_write,
	input wire logic [CMDSEL_NIF-1:0] req_start,
	input wire logic [CMDSEL_NIF-1:0] req_freq,
	input wire logic [CMDSEL_NIF-1:0] req_read,
	input wire logic rs485_modbus,
	// gated requests and status
	output logic [CMDSEL_NIF-1:0] write_ok,
	output logic [CMDSEL_NIF-1:0] start_ok,
	output logic [CMDSEL_NIF-1:0] freq_ok,
	output logic [CMDSEL_NIF-1:0] read_ok,
	output logic [CMDSEL_NIF-1:0] owner,
	output logic start_from_ext,
	output logic freq_from_ext,
	output logic analog_ignore,
	output logic net_switch_block,
	output logic lamps_enable
);
	// stored settings and the copies that act
	logic [15:0] start_r = CMDSEL_START_RST;
	logic [15:0] freq_r = CMDSEL_FREQ_RST;
	logic [15:0] net_r = CMDSEL_NET_RST;
	logic [15:0] panel_r = CMDSEL_PANEL_RST;
	logic [15:0] start_act_r, freq_act_r, net_act_r, panel_act_r;
	logic load_r;
	logic [CMDSEL_NIF-1:0] pu_own, net_own, own_nxt;
	logic net_blk, wr_allow, wr_legal;
	logic [15:0] rd_nxt;
	logic [CMDSEL_NIF-1:0] w_nxt, s_nxt, f_nxt;
	logic sx_nxt, fx_nxt, an_nxt;

	// legal setting values per register
	function automatic logic legal(input logic [1:0] sel,
		input logic [15:0] v);
		case (sel)
			CMDSEL_REG_START: legal = v <= CMDSEL_SRC_EXT;
			CMDSEL_REG_FREQ: legal = v <= CMDSEL_SRC_EXT_FB;
			CMDSEL_REG_NET: legal = v == CMDSEL_NET_OPTION ||
				v == CMDSEL_NET_PUCONN || v == CMDSEL_SET_AUTO;
			default: legal = (v >= CMDSEL_PU_PUCONN &&
				v <= CMDSEL_PU_PANEL) || v == CMDSEL_SET_AUTO;
		endcase
	endfunction

	// write gating ignores write protection entirely
	assign wr_allow = (user_group_read_selection == 16'h0000) ||
		option_fit;
	assign wr_legal = set_wr && wr_allow && legal(set_sel, set_wdata);

	// stored settings survive rst so that a new value acts after it;
	// they hold their reset values from power-up until written
	always_ff @(posedge clk) begin
		if (!rst && ce && wr_legal) begin
			case (set_sel)
				CMDSEL_REG_START: start_r <= set_wdata;
				CMDSEL_REG_FREQ: freq_r <= set_wdata;
				CMDSEL_REG_NET: net_r <= set_wdata;
				default: panel_r <= set_wdata;
			endcase
		end
	end

	// acting copies load once after reset release only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			load_r <= 1'b1;
			start_act_r <= CMDSEL_START_RST;
			freq_act_r <= CMDSEL_FREQ_RST;
			net_act_r <= CMDSEL_NET_RST;
			panel_act_r <= CMDSEL_PANEL_RST;
		end else if (ce && load_r) begin
			load_r <= 1'b0;
			start_act_r <= start_r;
			freq_act_r <= freq_r;
			net_act_r <= net_r;
			panel_act_r <= panel_r;
		end
	end

	// decode owners from acting settings
	cmdsel_grant u_grant (
		.net_set(net_act_r),
		.pu_set(panel_act_r),
		.usb_att(usb_att),
		.punit_att(punit_att),
		.option_fit(option_fit),
		.pu_owner(pu_own),
		.net_owner(net_own),
		.net_block(net_blk)
	);

	// owner by mode; external mode has no communication owner
	assign own_nxt = (mode == CMDSEL_MODE_PU) ? pu_own :
		(mode == CMDSEL_MODE_NET && !net_blk) ? net_own : 5'h00;

	// gating: owner only, modbus refused outside network mode
	assign w_nxt = req_write & own_nxt &
		~((rs485_modbus && mode != CMDSEL_MODE_NET) ?
		(5'h01 << CMDSEL_IF_RS485) : 5'h00);
	assign sx_nxt = start_act_r == CMDSEL_SRC_EXT;
	assign s_nxt = sx_nxt ? 5'h00 : (req_start & w_nxt | req_start &
		own_nxt & ~(req_write & ~w_nxt) & ~((rs485_modbus &&
		mode != CMDSEL_MODE_NET) ? (5'h01 << CMDSEL_IF_RS485) :
		5'h00));
	assign fx_nxt = (freq_act_r == CMDSEL_SRC_EXT) ||
		(freq_act_r == CMDSEL_SRC_EXT_FB && ext_freq_present);
	assign an_nxt = freq_act_r == CMDSEL_SRC_EXT_FB && !ext_freq_present;
	assign f_nxt = fx_nxt ? 5'h00 : req_freq & own_nxt &
		~((rs485_modbus && mode != CMDSEL_MODE_NET) ?
		(5'h01 << CMDSEL_IF_RS485) : 5'h00);

	// read mux of stored settings
	assign rd_nxt = (rd_sel == CMDSEL_REG_START) ? start_r :
		(rd_sel == CMDSEL_REG_FREQ) ? freq_r :
		(rd_sel == CMDSEL_REG_NET) ? net_r : panel_r;

	// registered outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			owner <= 5'h00;
			write_ok <= 5'h00;
			start_ok <= 5'h00;
			freq_ok <= 5'h00;
			read_ok <= 5'h00;
			start_from_ext <= 1'b0;
			freq_from_ext <= 1'b0;
			analog_ignore <= 1'b0;
			net_switch_block <= 1'b0;
			lamps_enable <= 1'b0;
			rd_data <= 16'h0000;
			set_wr_ack <= 1'b0;
			set_wr_nak <= 1'b0;
		end else if (ce) begin
			owner <= own_nxt;
			write_ok <= w_nxt;
			start_ok <= s_nxt;
			freq_ok <= f_nxt;
			read_ok <= req_read;
			start_from_ext <= sx_nxt;
			freq_from_ext <= fx_nxt;
			analog_ignore <= an_nxt;
			net_switch_block <= net_blk;
			lamps_enable <= mode != CMDSEL_MODE_PU ||
				own_nxt[CMDSEL_IF_PANEL];
			rd_data <= rd_nxt;
			set_wr_ack <= wr_legal;
			set_wr_nak <= set_wr && !wr_legal;
		end
	end

	// each right held by at most one interface
	owner_onehot_a: assert property (@(posedge clk)
		disable iff (rst) $onehot0(owner))
		else $error("two owners at once");
	// writes only from the owner
	write_owner_a: assert property (@(posedge clk)
		disable iff (rst) (write_ok & ~owner) == 5'h00)
		else $error("write by non owner");
	// starts only from the owner
	start_owner_a: assert property (@(posedge clk)
		disable iff (rst) (start_ok & ~owner) == 5'h00)
		else $error("start by non owner");
	// frequency commands only from the owner
	freq_owner_a: assert property (@(posedge clk)
		disable iff (rst) (freq_ok & ~owner) == 5'h00)
		else $error("frequency by non owner");
	// settings act only after a reset
	settings_hold_a: assert property (@(posedge clk)
		disable iff (rst) !load_r && ce |=>
		$stable(start_act_r) && $stable(freq_act_r) &&
		$stable(net_act_r) && $stable(panel_act_r))
		else $error("acting setting changed");
	// network mode blocked without option when option granted
	net_block_a: assert property (@(posedge clk)
		disable iff (rst) ce && !option_fit &&
		net_act_r == CMDSEL_NET_OPTION |=> net_switch_block)
		else $error("network not blocked");
	// external start gives no communication start
	start_ext_a: assert property (@(posedge clk)
		disable iff (rst) start_from_ext |-> start_ok == 5'h00)
		else $error("comm start with external source");
	// external frequency gives no communication frequency
	freq_ext_a: assert property (@(posedge clk)
		disable iff (rst) freq_from_ext |-> freq_ok == 5'h00)
		else $error("comm frequency with external source");
	// fallback setting with no external input ignores the analog pin
	analog_fallback_a: assert property (@(posedge clk)
		disable iff (rst) ce && freq_act_r == CMDSEL_SRC_EXT_FB &&
		!ext_freq_present |=> analog_ignore && !freq_from_ext)
		else $error("analog input not ignored");
	// option setting gives network rights to a fitted option
	net_option_a: assert property (@(posedge clk)
		disable iff (rst) ce && mode == CMDSEL_MODE_NET &&
		net_act_r == CMDSEL_NET_OPTION && option_fit |=>
		owner == (5'h01 << CMDSEL_IF_OPTION))
		else $error("option lacks network rights");
	// connector setting gives network rights to rs485
	net_fixed_a: assert property (@(posedge clk)
		disable iff (rst) ce && mode == CMDSEL_MODE_NET &&
		net_act_r == CMDSEL_NET_PUCONN &&
		(option_fit || panel_act_r != CMDSEL_PU_PUCONN) |=>
		owner == (5'h01 << CMDSEL_IF_RS485))
		else $error("rs485 lacks network rights");
	// auto network setting: option when fitted, else rs485
	net_auto_a: assert property (@(posedge clk)
		disable iff (rst) ce && mode == CMDSEL_MODE_NET &&
		net_act_r == CMDSEL_SET_AUTO |=>
		owner == ($past(option_fit) ? (5'h01 << CMDSEL_IF_OPTION) :
		(5'h01 << CMDSEL_IF_RS485)))
		else $error("wrong automatic network owner");
	// usb setting gives local rights to usb
	pu_fixed_a: assert property (@(posedge clk)
		disable iff (rst) ce && mode == CMDSEL_MODE_PU &&
		panel_act_r == CMDSEL_PU_USB |=>
		owner == (5'h01 << CMDSEL_IF_USB))
		else $error("usb lacks local rights");
	// auto local setting puts an attached usb first
	pu_auto_a: assert property (@(posedge clk)
		disable iff (rst) ce && mode == CMDSEL_MODE_PU &&
		panel_act_r == CMDSEL_SET_AUTO && usb_att |=>
		owner == (5'h01 << CMDSEL_IF_USB))
		else $error("usb not first in automatic choice");
	// rs485 gets local rights only by the connector setting
	rs485_local_a: assert property (@(posedge clk)
		disable iff (rst) ce && mode == CMDSEL_MODE_PU &&
		panel_act_r != CMDSEL_PU_PUCONN |=> !owner[CMDSEL_IF_RS485])
		else $error("rs485 took local rights");
	// both on the connector with no option blocks network mode
	both_pu_a: assert property (@(posedge clk)
		disable iff (rst) ce && !option_fit &&
		net_act_r == CMDSEL_NET_PUCONN &&
		panel_act_r == CMDSEL_PU_PUCONN |=> net_switch_block)
		else $error("network mode not blocked");
	// lamps off when panel is not the source in local mode
	lamps_off_a: assert property (@(posedge clk)
		disable iff (rst) ce && mode == CMDSEL_MODE_PU &&
		!own_nxt[CMDSEL_IF_PANEL] |=> !lamps_enable)
		else $error("lamps lit");
	// modbus on rs485 never passes in local mode
	modbus_reject_a: assert property (@(posedge clk)
		disable iff (rst) ce && rs485_modbus &&
		mode == CMDSEL_MODE_PU |=> !write_ok[CMDSEL_IF_RS485] &&
		!start_ok[CMDSEL_IF_RS485] && !freq_ok[CMDSEL_IF_RS485])
		else $error("modbus passed in local mode");
	// reads always answered
	read_any_a: assert property (@(posedge clk)
		disable iff (rst) ce |=> read_ok == $past(req_read))
		else $error("read refused");
	// network and local settings writable with write protection at 0 or 1
	wp_ignored_a: assert property (@(posedge clk)
		disable iff (rst) ce && set_wr && option_fit &&
		write_protect_selection <= 16'h0001 &&
		(set_sel == CMDSEL_REG_NET || set_sel == CMDSEL_REG_PANEL) &&
		legal(set_sel, set_wdata) |=> set_wr_ack)
		else $error("write protection applied");
	// no group permission and no option refuses the write
	group_gate_a: assert property (@(posedge clk)
		disable iff (rst) ce && set_wr && !option_fit &&
		user_group_read_selection != 16'h0000 |=> set_wr_nak)
		else $error("write let through without permission");
	// enable low freezes the registered outputs
	ce_freeze_a: assert property (@(posedge clk)
		disable iff (rst) !ce |=> $stable(owner) &&
		$stable(write_ok) && $stable(start_ok) &&
		$stable(lamps_enable) && $stable(rd_data))
		else $error("state moved with enable low");
endmodule

// ---- tb/cmdsel_hosts.sv ----
// far side model: the interfaces that send requests to the block
`timescale 1ns/1ns
module cmdsel_hosts (
	// clock
	input wire logic clk,
	// request control from the bench
	input wire logic act,
	input wire logic [2:0] who,
	input wire logic modbus,
	// requests toward the block
	output logic [4:0] req_write,
	output logic [4:0] req_start,
	output logic [4:0] req_freq,
	output logic [4:0] req_read,
	output logic rs485_modbus
);
	logic [4:0] one;
	// only the chosen interface issues commands; every interface reads
	assign one = act ? 5'h01 << who : 5'h00;
	// quiet request lines from time zero
	initial begin
		{req_write, req_start, req_freq, req_read, rs485_modbus} = '0;
	end
	// requests move just after the edge and hold until the next change
	always @(posedge clk) begin
		#1;
		req_write = one;
		req_start = one;
		req_freq = one;
		req_read = act ? 5'h1f : 5'h00;
		rs485_modbus = act && modbus && who == 3'h3;
	end
endmodule

// ---- tb/cmdsel_top_tb.sv ----
// self-checking testbench for the command source selection block
`timescale 1ns/1ns
module cmdsel_top_tb;
	import cmdsel_pkg::*;
	logic clk = 0, rst = 1, set_wr = 0, usb_att = 0, punit_att = 0;
	logic option_fit = 0, ext_freq_present = 0, act = 0, modbus = 0;
	logic [1:0] set_sel = 2'h0, rd_sel = 2'h0;
	logic [15:0] set_wdata = 16'h0, ugr = 16'h0, wp = 16'h0, rd_data;
	logic [2:0] who = 3'h0;
	cmdsel_mode_t mode = CMDSEL_MODE_PU;
	logic [4:0] rq_w, rq_s, rq_f, rq_r, write_ok, start_ok, freq_ok, read_ok;
	logic [4:0] owner;
	logic rq_m, set_wr_ack, set_wr_nak, start_from_ext, freq_from_ext;
	logic analog_ignore, net_switch_block, lamps_enable;
	logic ce = 1;
	int n_mismatch = 0, compares = 0, cyc = 0;

	cmdsel_hosts hosts (.clk(clk), .act(act), .who(who), .modbus(modbus),
		.req_write(rq_w), .req_start(rq_s), .req_freq(rq_f),
		.req_read(rq_r), .rs485_modbus(rq_m));

	cmdsel_top DUT (.clk(clk), .rst(rst), .ce(ce), .set_wr(set_wr),
		.set_sel(set_sel), .set_wdata(set_wdata),
		.user_group_read_selection(ugr), .write_protect_selection(wp),
		.set_wr_ack(set_wr_ack), .set_wr_nak(set_wr_nak),
		.rd_sel(rd_sel), .rd_data(rd_data), .mode(mode),
		.usb_att(usb_att), .punit_att(punit_att), .option_fit(option_fit),
		.ext_freq_present(ext_freq_present), .req_write(rq_w),
		.req_start(rq_s), .req_freq(rq_f), .req_read(rq_r),
		.rs485_modbus(rq_m), .write_ok(write_ok), .start_ok(start_ok),
		.freq_ok(freq_ok), .read_ok(read_ok), .owner(owner),
		.start_from_ext(start_from_ext), .freq_from_ext(freq_from_ext),
		.analog_ignore(analog_ignore), .net_switch_block(net_switch_block),
		.lamps_enable(lamps_enable));

	// 250 MHz clock
	initial begin
		forever #2 clk = ~clk;
	end

	// hang guard, far above the hundred or so cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			summarize();
		end
	end

	task automatic summarize();
		if (n_mismatch == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// wait n edges, then step just past the last one
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// reset pulse; new settings start to act after it
	task automatic rstp(input int n);
		rst = 1;
		tick(n);
		rst = 0;
		tick(4);
	endtask

	// one-cycle write strobe; ack or nak stands the cycle after
	task automatic wr(input logic [1:0] s, input logic [15:0] d, input ok);
		set_wr = 1;
		set_sel = s;
		set_wdata = d;
		tick(1);
		set_wr = 0;
		chk("ack", set_wr_ack, ok);
		chk("nak", set_wr_nak, !ok);
		tick(1);
	endtask

	task automatic rd(input logic [1:0] s, input logic [15:0] exp);
		rd_sel = s;
		tick(2);
		chk("rd_data", rd_data, exp);
	endtask

	// main sequence
	initial begin
		rstp(20);
		rd(2'h0, 16'h0000);
		rd(2'h1, 16'h0000);
		rd(2'h2, 16'h270f);
		rd(2'h3, 16'h270f);
		// local auto: usb over parameter unit over panel
		usb_att = 1;
		punit_att = 1;
		tick(3);
		chk("owner", owner, 5'h02);
		usb_att = 0;
		tick(3);
		chk("owner", owner, 5'h04);
		punit_att = 0;
		act = 1;
		who = 3'h3;
		tick(3);
		chk("owner", owner, 5'h01);
		chk("start", start_ok, 5'h00);
		chk("read", read_ok, 5'h1f);
		chk("lamps", lamps_enable, 1'b1);
		who = 3'h0;
		tick(3);
		chk("start", start_ok, 5'h01);
		usb_att = 1;
		tick(3);
		chk("lamps", lamps_enable, 1'b0);
		// enable low freezes the registered owner
		ce = 0;
		usb_att = 0;
		tick(3);
		chk("owner", owner, 5'h02);
		ce = 1;
		// network auto: option when fitted, else the pu connector
		mode = CMDSEL_MODE_NET;
		who = 3'h3;
		tick(3);
		chk("owner", owner, 5'h08);
		chk("start", start_ok, 5'h08);
		option_fit = 1;
		tick(3);
		chk("owner", owner, 5'h10);
		chk("start", start_ok, 5'h00);
		// write permission and deferred effect
		ugr = 16'h1;
		option_fit = 0;
		wr(2'h2, 16'h0002, 0);
		option_fit = 1;
		wp = 16'h1;
		wr(2'h2, 16'h0002, 1);
		ugr = 16'h0;
		wr(2'h3, 16'h0003, 1);
		wr(2'h0, 16'h0001, 1);
		wr(2'h1, 16'h0002, 1);
		rd(2'h2, 16'h0002);
		tick(3);
		chk("owner", owner, 5'h10);
		rstp(2);
		chk("owner", owner, 5'h08);
		chk("start_ext", start_from_ext, 1'b1);
		chk("freq_ext", freq_from_ext, 1'b0);
		chk("analog", analog_ignore, 1'b1);
		ext_freq_present = 1;
		mode = CMDSEL_MODE_PU;
		tick(3);
		chk("freq_ext", freq_from_ext, 1'b1);
		chk("owner", owner, 5'h02);
		// both settings on the pu connector, no option
		wr(2'h3, 16'h0002, 1);
		wr(2'h0, 16'h0000, 1);
		option_fit = 0;
		rstp(2);
		chk("block", net_switch_block, 1'b1);
		chk("owner", owner, 5'h08);
		chk("start", start_ok, 5'h08);
		modbus = 1;
		tick(3);
		chk("start", start_ok, 5'h00);
		modbus = 0;
		// network rights to the option only
		wr(2'h2, 16'h0000, 1);
		rstp(2);
		chk("block", net_switch_block, 1'b1);
		option_fit = 1;
		mode = CMDSEL_MODE_NET;
		tick(3);
		chk("owner", owner, 5'h10);
		chk("block", net_switch_block, 1'b0);
		summarize();
	end
endmodule
